// file: src/afepc_power_control.sv
// Power sequencing and register file of the analog front-end power control block.
// Assumes an APB master on pclk and an analog bias level detector arriving asynchronously.
//
// The APB interface to the registers was chosen for this implementation.

`timescale 1ns/100ps

module afepc_power_control #(
	parameter int unsigned REF_CYCLES  = afepc_pkg::REF_SETTLE_CYCLES,
	parameter int unsigned REG_CYCLES  = afepc_pkg::REG_SETTLE_CYCLES,
	parameter int unsigned RISE_CYCLES = afepc_pkg::BIAS_RISE_CYCLES
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire afepc_pkg::afepc_apb_req_type apb_req,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         bias_detect_level,
	output afepc_pkg::afepc_power_type        power_enable,
	output logic [4:0]                        bias_code,
	output logic [7:0]                        peripheral_clock_enables
);
	import afepc_pkg::*;

	if (REF_CYCLES < 16 || REG_CYCLES < 16 || RISE_CYCLES < 16) begin : g_count_too_small
		$error("Settling counts must be at least 16 cycles.");
	end
	if (REF_CYCLES > 65535 || REG_CYCLES > 65535 || RISE_CYCLES > 65535) begin : g_count_too_large
		$error("Settling counts must fit in 16 bits.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register state and decode.

	logic [7:0]           peripheral_clock_enable_one;
	logic [7:0]           analog_power_select;
	logic [4:0]           sensor_bias_voltage_select;
	logic [7:0]           analog_power_detect;
	logic                 frontend_clock_enable;
	logic                 ack;
	logic                 hit_peripheral_clock_enable_one;
	logic                 hit_pws;
	logic                 hit_pwd;
	logic                 hit_vsb;
	logic                 mapped;
	logic                 code_ok;
	logic                 access;
	logic                 write_done;
	logic                 reference_power_stable;
	logic                 instr_amp_power_stable;
	logic                 reference_power_on;
	logic                 instr_amp_power_on;
	logic [15:0]          ref_count;
	logic [15:0]          reg_count;
	logic [15:0]          rise_count;
	logic                 regulator_settled;
	logic [2:0]           detect_sync;
	logic                 bias_output_detector;
	afepc_bias_state_type bias_state;
	afepc_bias_state_type next_bias_state;

	assign frontend_clock_enable = peripheral_clock_enable_one[PERIPHERAL_CLOCK_ENABLE_ONE_FCE_BIT];
	assign reference_power_on    = analog_power_select[PWS_REF_BIT];
	assign instr_amp_power_on    = analog_power_select[PWS_INSTR_BIT];

	always_comb begin
		hit_peripheral_clock_enable_one = 1'b0;
		hit_pws  = 1'b0;
		hit_pwd  = 1'b0;
		hit_vsb  = 1'b0;
		if (apb_req.paddr[23:2] == IDX_PERIPHERAL_CLOCK_ENABLE_ONE) begin
			hit_peripheral_clock_enable_one = 1'b1;
		end else if (apb_req.paddr[23:2] == IDX_ANALOG_POWER_SELECT) begin
			hit_pws = 1'b1;
		end else if (apb_req.paddr[23:2] == IDX_ANALOG_POWER_DETECT) begin
			hit_pwd = 1'b1;
		end else if (apb_req.paddr[23:2] == IDX_SENSOR_BIAS_VOLTAGE_SELECT) begin
			hit_vsb = 1'b1;
		end
	end

	assign mapped     = hit_peripheral_clock_enable_one | hit_pws | hit_pwd | hit_vsb;
	assign code_ok    = apb_req.pwdata[4:0] >= BIAS_CODE_MIN
	                    && apb_req.pwdata[4:0] <= BIAS_CODE_MAX;
	assign access     = apb_req.psel & apb_req.penable;
	assign write_done = access & ack & apb_req.pwrite & apb_req.pstrb[0];

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, read data latched in the first access cycle.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack <= 1'b0;
		end else begin
			ack <= access & ~ack;
		end
	end

	assign pready  = ack;
	assign pslverr = ack & (~mapped | (apb_req.pwrite & hit_vsb & ~code_ok));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (access & ~ack & ~apb_req.pwrite) begin
			if (hit_peripheral_clock_enable_one) begin
				prdata <= {24'h000000, peripheral_clock_enable_one};
			end else if (hit_pws) begin
				prdata <= {24'h000000, analog_power_select};
			end else if (hit_pwd) begin
				prdata <= {24'h000000, analog_power_detect};
			end else if (hit_vsb) begin
				prdata <= {27'h0000000, sensor_bias_voltage_select};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers.

	// Bit 4 is kept at zero whatever is written, so a careless write cannot set it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_clock_enable_one <= PERIPHERAL_CLOCK_ENABLE_ONE_RESET;
		end else if (write_done & hit_peripheral_clock_enable_one) begin
			peripheral_clock_enable_one <= apb_req.pwdata[7:0] & PERIPHERAL_CLOCK_ENABLE_ONE_WRITE_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_power_select <= PWS_RESET;
		end else if (!frontend_clock_enable) begin
			analog_power_select <= PWS_RESET;
		end else if (write_done & hit_pws) begin
			analog_power_select <= apb_req.pwdata[7:0] & PWS_WRITE_MASK;
		end
	end

	// A prohibited code is refused and the previous setting stays.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sensor_bias_voltage_select <= BIAS_CODE_RESET;
		end else if (!frontend_clock_enable) begin
			sensor_bias_voltage_select <= BIAS_CODE_RESET;
		end else if (write_done & hit_vsb & code_ok) begin
			sensor_bias_voltage_select <= apb_req.pwdata[4:0];
		end
	end

	assign peripheral_clock_enables = peripheral_clock_enable_one;
	assign bias_code                = sensor_bias_voltage_select;

	////////////////////////////////////////////////////////////////////////////////
	// Settling models for the reference generator and the internal regulator.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_count <= 16'h0000;
		end else if (!reference_power_on) begin
			ref_count <= 16'h0000;
		end else if (ref_count != REF_CYCLES[15:0]) begin
			ref_count <= ref_count + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_power_stable <= 1'b0;
		end else begin
			reference_power_stable <= reference_power_on
			                          && ref_count == REF_CYCLES[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_count <= 16'h0000;
		end else if (!(instr_amp_power_on && reference_power_on && reference_power_stable)) begin
			reg_count <= 16'h0000;
		end else if (reg_count != REG_CYCLES[15:0]) begin
			reg_count <= reg_count + 16'h0001;
		end
	end

	assign regulator_settled = reg_count == REG_CYCLES[15:0];

	////////////////////////////////////////////////////////////////////////////////
	// Bias output detector: synchronised and filtered, then sequenced.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detect_sync <= 3'h0;
		end else begin
			detect_sync <= {detect_sync[1:0], bias_detect_level};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_output_detector <= 1'b0;
		end else if (detect_sync[1] == detect_sync[2]) begin
			bias_output_detector <= detect_sync[2];
		end
	end

	// The fault state is left only by switching the supply off.
	always_comb begin
		next_bias_state = bias_state;
		case (bias_state)
			BIAS_OFF: begin
				if (power_enable.sensor_bias) begin
					next_bias_state = BIAS_RISING;
				end
			end
			BIAS_RISING: begin
				if (!power_enable.sensor_bias) begin
					next_bias_state = BIAS_OFF;
				end else if (bias_output_detector) begin
					next_bias_state = BIAS_ACTIVE;
				end else if (rise_count == RISE_CYCLES[15:0]) begin
					next_bias_state = BIAS_FAULT;
				end
			end
			BIAS_ACTIVE: begin
				if (!power_enable.sensor_bias) begin
					next_bias_state = BIAS_OFF;
				end else if (!bias_output_detector) begin
					next_bias_state = BIAS_FAULT;
				end
			end
			BIAS_FAULT: begin
				if (!power_enable.sensor_bias) begin
					next_bias_state = BIAS_OFF;
				end
			end
			default: begin
				next_bias_state = BIAS_OFF;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_state <= BIAS_OFF;
		end else begin
			bias_state <= next_bias_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_count <= 16'h0000;
		end else if (bias_state != BIAS_RISING) begin
			rise_count <= 16'h0000;
		end else if (rise_count != RISE_CYCLES[15:0]) begin
			rise_count <= rise_count + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog enables and power detect status.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_enable <= '0;
		end else begin
			power_enable.reference   <= reference_power_on;
			power_enable.dac         <= reference_power_on
			                            & analog_power_select[PWS_DAC_BIT];
			power_enable.amp         <= {3{reference_power_on}}
			                            & analog_power_select[PWS_AMP_LSB +: 3];
			power_enable.regulator   <= reference_power_on & instr_amp_power_on
			                            & reference_power_stable;
			power_enable.sensor_bias <= reference_power_on & instr_amp_power_on
			                            & reference_power_stable;
			power_enable.bias_amp    <= reference_power_on & instr_amp_power_on
			                            & next_bias_state == BIAS_ACTIVE;
			power_enable.instr_amp   <= reference_power_on & instr_amp_power_on
			                            & next_bias_state == BIAS_ACTIVE;
			power_enable.converter   <= reference_power_on & instr_amp_power_on
			                            & next_bias_state == BIAS_ACTIVE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_amp_power_stable <= 1'b0;
		end else begin
			instr_amp_power_stable <= reference_power_on && instr_amp_power_on
			                          && reference_power_stable && regulator_settled
			                          && bias_state == BIAS_ACTIVE;
		end
	end

	always_comb begin
		analog_power_detect                = 8'h00;
		analog_power_detect[PWD_REF_BIT]   = reference_power_stable;
		analog_power_detect[PWD_INSTR_BIT] = instr_amp_power_stable;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_write_done;
		apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.pstrb[0];
	endsequence

	sequence s_ref_held_on;
		$rose(reference_power_on) ##0 reference_power_on [*8];
	endsequence

	a_locked_registers: assert property (@(posedge pclk) disable iff (!presetn)
		!frontend_clock_enable |=> analog_power_select == PWS_RESET
		                           && sensor_bias_voltage_select == BIAS_CODE_RESET)
		else $error("Front-end registers not held in reset while clock enable is low.");

	a_select_write: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_done ##0 (hit_pws && frontend_clock_enable)
		|=> analog_power_select == ($past(apb_req.pwdata[7:0]) & PWS_WRITE_MASK))
		else $error("Power select write did not take effect.");

	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!peripheral_clock_enable_one[4] && !analog_power_select[1] && !analog_power_select[3])
		else $error("Reserved bit stored as one.");

	a_detect_unused: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !ack && !apb_req.pwrite && hit_pwd)
		|=> prdata[31:3] == 29'h00000000 && !prdata[1])
		else $error("Unused power detect bits read as one.");

	a_amp_status: assert property (@(posedge pclk) disable iff (!presetn)
		instr_amp_power_stable |-> $past(regulator_settled) && $past(bias_state == BIAS_ACTIVE))
		else $error("Amplifier status set before regulator and bias settled.");

	a_ref_settle_min: assert property (@(posedge pclk) disable iff (!presetn)
		s_ref_held_on |-> !reference_power_stable)
		else $error("Reference status rose before the settling delay.");

	a_ref_status_drop: assert property (@(posedge pclk) disable iff (!presetn)
		!reference_power_on |=> !reference_power_stable)
		else $error("Reference status did not clear after power-off.");

	a_amp_under_ref: assert property (@(posedge pclk) disable iff (!presetn)
		instr_amp_power_stable |-> reference_power_stable)
		else $error("Amplifier status high while reference status low.");

	a_bias_range: assert property (@(posedge pclk) disable iff (!presetn)
		bias_code >= BIAS_CODE_MIN && bias_code <= BIAS_CODE_MAX)
		else $error("Bias code outside the permitted range.");

	a_amp_enables: assert property (@(posedge pclk) disable iff (!presetn)
		##1 power_enable.amp == ($past(analog_power_select[6:4]) & {3{$past(reference_power_on)}})
		&& power_enable.reference == $past(reference_power_on))
		else $error("Amplifier or reference enable does not follow its power bit.");

	a_start_gated: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(power_enable.instr_amp) |-> bias_state == BIAS_ACTIVE && power_enable.converter)
		else $error("Dependent circuits started without bias detection.");

	a_fault_stops: assert property (@(posedge pclk) disable iff (!presetn)
		bias_state == BIAS_FAULT |-> !power_enable.converter && !power_enable.bias_amp)
		else $error("Dependent circuits running during a bias fault.");

	a_ref_off_stops: assert property (@(posedge pclk) disable iff (!presetn)
		!reference_power_on |=> !power_enable.sensor_bias && !power_enable.bias_amp
		                        && !power_enable.instr_amp && !power_enable.converter)
		else $error("Circuits still enabled after reference power-off.");

endmodule : afepc_power_control

// file: src/afepc_pkg.sv
// Constants, register map and carrier types of the analog front-end power control block.
// Assumes an APB master with 32-bit data and byte addresses equal to four times the index.
//
// Overview of operation
// - Front-end clock enable low holds the front-end registers in reset and ignores writes to them.
// - Front-end clock enable high lets software read and write the front-end registers.
// - Peripheral clock enable register takes bit or byte writes and resets to zero.
// - Clearing the front-end clock enable resets every power-on bit to off.
// - Power select register resets to zero and takes bit or byte writes.
// - Power select bits 4 to 6 switch the three configurable amplifiers.
// - Power select bit 0 switches the reference generator feeding all other supplies.
// - Power detect register is read-only, resets to zero, unused bits read zero.
// - Detect bit 2 reads one only once the amplifier-block supplies are stable.
// - Amplifier-block status combines the internal regulator and sensor bias supply.
// - Detect bit 0 reads one once the reference generator is stable.
// - Bias voltage register resets to 10H, byte writes only, upper bits read zero.
// - Bias codes 01001 to 11010 select 0.5 V to 2.2 V; others prohibited.
// - Bias amplifier, instrumentation amplifier and converter start only after bias detection.
// - A bias output that fails to rise properly stops the dependent circuits.
// - Clearing the reference bit stops sensor bias, bias amplifier, amplifier and converter.

package afepc_pkg;

	localparam int unsigned CLOCK_MHZ = 125;

	// Register indexes; the byte address is four times the index.
	localparam logic [21:0] IDX_PERIPHERAL_CLOCK_ENABLE_ONE = 22'h0F007A;
	localparam logic [21:0] IDX_ANALOG_POWER_SELECT         = 22'h0F0440;
	localparam logic [21:0] IDX_ANALOG_POWER_DETECT         = 22'h0F0441;
	localparam logic [21:0] IDX_SENSOR_BIAS_VOLTAGE_SELECT  = 22'h0F0443;

	localparam logic [7:0] PERIPHERAL_CLOCK_ENABLE_ONE_RESET        = 8'h00;
	localparam logic [7:0] PERIPHERAL_CLOCK_ENABLE_ONE_WRITE_MASK   = 8'hEF;
	localparam int unsigned PERIPHERAL_CLOCK_ENABLE_ONE_FCE_BIT     = 1;
	localparam logic [7:0] PWS_RESET         = 8'h00;
	localparam logic [7:0] PWS_WRITE_MASK    = 8'hF5;
	localparam int unsigned PWS_REF_BIT      = 0;
	localparam int unsigned PWS_INSTR_BIT    = 2;
	localparam int unsigned PWS_AMP_LSB      = 4;
	localparam int unsigned PWS_DAC_BIT      = 7;
	localparam int unsigned PWD_REF_BIT      = 0;
	localparam int unsigned PWD_INSTR_BIT    = 2;
	localparam logic [4:0] BIAS_CODE_RESET   = 5'h10;
	localparam logic [4:0] BIAS_CODE_MIN     = 5'h09;
	localparam logic [4:0] BIAS_CODE_MAX     = 5'h1A;

	// Modelled settling and rise times in nanoseconds.
	localparam int unsigned REF_SETTLE_NS    = 10000;
	localparam int unsigned REG_SETTLE_NS    = 20000;
	localparam int unsigned BIAS_RISE_NS     = 30000;
	localparam int unsigned REF_SETTLE_CYCLES  = REF_SETTLE_NS * CLOCK_MHZ / 1000;
	localparam int unsigned REG_SETTLE_CYCLES  = REG_SETTLE_NS * CLOCK_MHZ / 1000;
	localparam int unsigned BIAS_RISE_CYCLES   = BIAS_RISE_NS * CLOCK_MHZ / 1000;

	typedef enum logic [3:0] {
		BIAS_OFF    = 4'h1,
		BIAS_RISING = 4'h2,
		BIAS_ACTIVE = 4'h4,
		BIAS_FAULT  = 4'h8
	} afepc_bias_state_type;

	typedef struct packed {
		logic       dac;
		logic [2:0] amp;
		logic       instr_amp;
		logic       converter;
		logic       bias_amp;
		logic       sensor_bias;
		logic       regulator;
		logic       reference;
	} afepc_power_type;

	typedef struct packed {
		logic [23:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} afepc_apb_req_type;

endpackage : afepc_pkg

// file: testbench/tb_top.sv
// Self-checking bench for the front-end power control block, driven over APB.
// Assumes afepc_pkg and afepc_power_control are compiled before this file.

`timescale 1ns/100ps

module tb_top;
	import afepc_pkg::*;

	localparam int unsigned SETTLE = 20;
	localparam logic [23:0] A_PCE  = {IDX_PERIPHERAL_CLOCK_ENABLE_ONE, 2'b00};
	localparam logic [23:0] A_PWS  = {IDX_ANALOG_POWER_SELECT, 2'b00};
	localparam logic [23:0] A_PWD  = {IDX_ANALOG_POWER_DETECT, 2'b00};
	localparam logic [23:0] A_BIAS = {IDX_SENSOR_BIAS_VOLTAGE_SELECT, 2'b00};
	localparam logic [23:0] A_BAD  = A_PWD + 24'h4;

	typedef struct packed {
		logic [23:0] addr;
		logic        wr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        err;
	} afepc_row_type;

	logic              pclk;
	logic              presetn;
	afepc_apb_req_type apb_req;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              bias_detect_level;
	afepc_power_type   power_enable;
	logic [4:0]        bias_code;
	logic [7:0]        peripheral_clock_enables;
	logic [31:0]       rdv;
	logic              erv;
	int                bad_count;
	int                n_checks;
	int                cycles;

	afepc_row_type rows [20] = '{
		'{A_PCE, 0, 8'h00, 8'h00, 0}, '{A_PWS, 0, 8'h00, 8'h00, 0},
		'{A_PWD, 0, 8'h00, 8'h00, 0}, '{A_BIAS, 0, 8'h00, 8'h10, 0},
		'{A_PWS, 1, 8'hFF, 8'h00, 0}, '{A_PWS, 0, 8'h00, 8'h00, 0},
		'{A_PCE, 1, 8'hFF, 8'h00, 0}, '{A_PCE, 0, 8'h00, 8'hEF, 0},
		'{A_PWD, 1, 8'hFF, 8'h00, 0}, '{A_PWD, 0, 8'h00, 8'h00, 0},
		'{A_BIAS, 1, 8'h08, 8'h00, 1}, '{A_BIAS, 1, 8'h1B, 8'h00, 1},
		'{A_BIAS, 0, 8'h00, 8'h10, 0}, '{A_BIAS, 1, 8'h09, 8'h00, 0},
		'{A_BIAS, 0, 8'h00, 8'h09, 0}, '{A_BIAS, 1, 8'h1A, 8'h00, 0},
		'{A_BIAS, 0, 8'h00, 8'h1A, 0}, '{A_BAD, 0, 8'h00, 8'h00, 1},
		'{A_PWS, 1, 8'h0A, 8'h00, 0}, '{A_PWS, 0, 8'h00, 8'h00, 0}
	};

	afepc_power_control #(
		.REF_CYCLES  (SETTLE),
		.REG_CYCLES  (SETTLE),
		.RISE_CYCLES (SETTLE)
	) dut (
		.pclk                     (pclk),
		.presetn                  (presetn),
		.apb_req                  (apb_req),
		.prdata                   (prdata),
		.pready                   (pready),
		.pslverr                  (pslverr),
		.bias_detect_level        (bias_detect_level),
		.power_enable             (power_enable),
		.bias_code                (bias_code),
		.peripheral_clock_enables (peripheral_clock_enables)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	// A hung handshake would otherwise stall the run forever.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic [23:0] a, input logic w, input logic [7:0] d);
		@(posedge pclk);
		apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
			pwdata: {24'h0, d}, pstrb: 4'hF};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	task automatic wait_pwd(input logic [7:0] exp);
		rdv = 32'hFFFFFFFF;
		for (int i = 0; i < 200 && rdv !== {24'h0, exp}; i++) begin
			apb(A_PWD, 1'b0, 8'h00);
			check({31'h0, rdv[2] & ~rdv[0]}, 32'h0);
		end
	endtask : wait_pwd

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		apb_req = '0;
		bias_detect_level = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].addr, rows[i].wr, rows[i].wdata);
			check({31'h0, erv}, {31'h0, rows[i].err});
			if (!rows[i].wr) check(rdv, {24'h0, rows[i].rdata});
		end
		check({24'h0, peripheral_clock_enables}, 32'hEF);
		check({27'h0, bias_code}, 32'h1A);
		apb(A_PWS, 1'b1, 8'h01);
		repeat (2) @(posedge pclk);
		check({21'h0, power_enable}, 32'h001);
		apb(A_PWD, 1'b0, 8'h00);
		check(rdv, 32'h0);
		wait_pwd(8'h01);
		check(rdv, 32'h01);
		apb(A_PWS, 1'b1, 8'h05);
		repeat (3) @(posedge pclk);
		check({30'h0, power_enable.sensor_bias, power_enable.converter}, 32'h2);
		repeat (SETTLE + 10) @(posedge pclk);
		// A detector that rises only after the timeout must not revive the dependent circuits.
		bias_detect_level <= 1'b1;
		repeat (8) @(posedge pclk);
		check({30'h0, power_enable.converter, power_enable.bias_amp}, 32'h0);
		apb(A_PWS, 1'b1, 8'h01);
		apb(A_PWS, 1'b1, 8'h05);
		repeat (10) @(posedge pclk);
		check({29'h0, power_enable.converter, power_enable.bias_amp,
			power_enable.instr_amp}, 32'h7);
		wait_pwd(8'h05);
		check(rdv, 32'h05);
		apb(A_PWS, 1'b1, 8'hF5);
		repeat (2) @(posedge pclk);
		check({28'h0, power_enable.amp, power_enable.dac}, 32'hF);
		apb(A_PWS, 1'b1, 8'h85);
		repeat (2) @(posedge pclk);
		check({29'h0, power_enable.amp}, 32'h0);
		bias_detect_level <= 1'b0;
		repeat (8) @(posedge pclk);
		check({31'h0, power_enable.converter}, 32'h0);
		apb(A_PWS, 1'b1, 8'h05);
		apb(A_PWS, 1'b1, 8'h00);
		repeat (2) @(posedge pclk);
		check({21'h0, power_enable}, 32'h0);
		apb(A_PWD, 1'b0, 8'h00);
		check(rdv, 32'h0);
		apb(A_PWS, 1'b1, 8'hF5);
		apb(A_PCE, 1'b1, 8'hED);
		repeat (3) @(posedge pclk);
		check({21'h0, power_enable}, 32'h0);
		check({27'h0, bias_code}, 32'h10);
		apb(A_PWS, 1'b0, 8'h00);
		check(rdv, 32'h0);
		apb(A_PCE, 1'b1, 8'h02);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		check({19'h0, peripheral_clock_enables, bias_code}, 32'h10);
		presetn <= 1'b1;
		finish_test();
	end
endmodule : tb_top
